//--- logic/wdcm_pin_sync.sv
`timescale 1ns/1ns

// ==========================================================
// three-stage pin synchroniser, output moves when stages two and three agree
module wdcm_pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] stable_q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                    stable_q[i] <= RST_VAL[i];
                end else begin
                    s1_q <= pins_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        stable_q[i] <= s3_q;
                    end
                end
            end
        end
    endgenerate

endmodule // wdcm_pin_sync

//--- logic/wdcm_pkg.sv
package wdcm_pkg;

    // ==========================================================
    // service register layout
    localparam int SVR_WIDTH = 8;
    localparam int WIN_MSB = 7;
    localparam int WIN_LSB = 6;
    localparam int KEY_MSB = 5;
    localparam int KEY_LSB = 1;
    localparam int CM_BIT = 0;
    localparam logic [4:0] KEY_VALUE = 5'h0C;
    localparam logic [4:0] KEY_READ = 5'h00;
    localparam logic [1:0] WIN_SEL_RESET = 2'h3;
    localparam logic CM_EN_RESET = 1'b1;

    // ==========================================================
    // window limits in instruction cycles
    localparam logic [8:0] LOWER_LIMIT = 9'h100;
    localparam logic [15:0] UPPER_LAST_8K = 16'h1FFF;
    localparam logic [15:0] UPPER_LAST_16K = 16'h3FFF;
    localparam logic [15:0] UPPER_LAST_32K = 16'h7FFF;
    localparam logic [15:0] UPPER_LAST_64K = 16'hFFFF;
    localparam logic [4:0] RELEASE_TC = 5'h18;

    // ==========================================================
    // clock monitor timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CM_MAX_GAP_NS = 1000000;
    localparam int CM_TIMEOUT_CYC = CM_MAX_GAP_NS / CLK_PERIOD_NS;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        WDCM_RUN = 2'b00,
        WDCM_PULL = 2'b01,
        WDCM_HOLD = 2'b10,
        WDCM_WAIT_HIGH = 2'b11
    } wdcm_state_e;

    typedef struct packed {
        logic wr;
        logic [SVR_WIDTH-1:0] data;
    } wdcm_svr_req_s;

endpackage

//--- logic/wdcm_watchdog.sv
`timescale 1ns/1ns

// What this block does
// - earliest legal service is 256 instruction cycles after window restart
// - service bits 7:6 pick upper limit 8k, 16k, 32k or 64k cycles
// - key field bits 5:1 must be 01100 on every service write
// - service bit 0 enables the clock monitor
// - watchdog active only when option bit 2 is 0; fault pin has pull-up
// - inhibited in reset; leaves reset with 64k window and monitor on
// - a clock too slow after reset, or dead, flags a monitor error
// - first keyed write after reset locks window and monitor enable
// - later writes are compared against stored bits 7:6 and bit 0
// - full match restarts window; any mismatch drives the fault pin
// - no valid service before upper limit gives a watchdog error
// - later service inside the lower interval is an error; between limits it restarts the window
// - the configuring write also counts as a service
// - fault pin active low, high only through weak pull-up
// - after pin sensed low keep driving 16 to 32 cycles then release
// - window restarts when the fault pin returns high
// - service writes while the fault pin is active are ignored
// - monitor holds pin low during error, releases 16 to 32 cycles after recovery
// - clock above 10 kHz never rejected, below 10 Hz always rejected
// - reads of the service register return zeros in the key field
// - timeout detection is inhibited in halt and idle
// - pin low at power-on leads to a timeout and then release
// - clock monitor keeps watching during halt and idle
// - leaving idle performs an automatic service
module wdcm_watchdog #(
    parameter int CM_TIMEOUT_CYC = wdcm_pkg::CM_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // core status
    input wire logic instr_cycle_en,
    input wire logic opt_wd_disable,
    input wire logic halt_mode,
    input wire logic idle_mode,
    // service register access
    input wire wdcm_pkg::wdcm_svr_req_s svr_req,
    output logic [7:0] service_key_rdata,
    // pins
    input wire logic oscillator_input_pin,
    input wire logic port_g_bit_one_in,
    output logic port_g_bit_one_out,
    output logic port_g_bit_one_oe_n,
    output logic port_g_bit_one_pullup_en
);

    localparam int CMW = $clog2(CM_TIMEOUT_CYC + 1);
    localparam logic [CMW-1:0] CM_LAST = CMW'(CM_TIMEOUT_CYC);
    localparam logic [CMW-1:0] CM_ONE = CMW'(1);

    // ==========================================================
    // pin sampling
    logic [1:0] pin_stable;
    wire logic osc_level;
    wire logic fault_pin_high;

    wdcm_pin_sync #(
        .WIDTH(2),
        .RST_VAL(2'h2)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pins_in({port_g_bit_one_in, oscillator_input_pin}),
        .stable_q(pin_stable)
    );

    assign osc_level = pin_stable[0];
    assign fault_pin_high = pin_stable[1];

    // ==========================================================
    // state
    wdcm_pkg::wdcm_state_e state_q;
    wdcm_pkg::wdcm_state_e state_d;
    logic cfg_done_q;
    logic [1:0] win_sel_q;
    logic cm_en_q;
    logic [15:0] upper_limit_counter_q;
    logic [8:0] lower_limit_counter_q;
    logic [4:0] hold_q;
    logic idle_q;
    logic osc_prev_q;
    logic [CMW-1:0] cm_cnt_q;
    logic [4:0] cm_rel_q;
    logic oe_n_q;

    // ==========================================================
    // decode
    wire logic wd_active;
    wire logic tick;
    wire logic in_run;
    wire logic running;
    wire logic idle_exit;
    wire logic key_ok;
    wire logic full_ok;
    wire logic lower_done;
    wire logic wr_take;
    wire logic first_ok;
    wire logic later_ok;
    wire logic svc;
    wire logic bad_wr;
    wire logic [15:0] upper_last;
    wire logic timeout;
    wire logic wd_err;
    wire logic restart;
    wire logic hold_end;
    wire logic osc_edge;
    wire logic cm_mon_en;
    wire logic cm_fail;
    wire logic cm_drive;
    wire logic wd_drive;

    assign wd_active = ~opt_wd_disable;
    assign tick = instr_cycle_en & wd_active;
    assign in_run = (state_q == wdcm_pkg::WDCM_RUN);
    assign running = in_run & ~halt_mode & ~idle_mode;
    assign idle_exit = idle_q & ~idle_mode;

    assign key_ok = (svr_req.data[wdcm_pkg::KEY_MSB:wdcm_pkg::KEY_LSB] == wdcm_pkg::KEY_VALUE);
    assign full_ok = key_ok
        & (svr_req.data[wdcm_pkg::WIN_MSB:wdcm_pkg::WIN_LSB] == win_sel_q)
        & (svr_req.data[wdcm_pkg::CM_BIT] == cm_en_q);
    assign lower_done = (lower_limit_counter_q == wdcm_pkg::LOWER_LIMIT);

    assign wr_take = svr_req.wr & wd_active & in_run;
    assign first_ok = wr_take & ~cfg_done_q & key_ok;
    assign later_ok = wr_take & cfg_done_q & full_ok & lower_done;
    assign svc = first_ok | later_ok | (idle_exit & in_run & wd_active);
    assign bad_wr = wr_take & ~(first_ok | later_ok);

    assign upper_last = (win_sel_q == 2'h0) ? wdcm_pkg::UPPER_LAST_8K :
                        (win_sel_q == 2'h1) ? wdcm_pkg::UPPER_LAST_16K :
                        (win_sel_q == 2'h2) ? wdcm_pkg::UPPER_LAST_32K :
                        wdcm_pkg::UPPER_LAST_64K;
    assign timeout = running & tick & (upper_limit_counter_q == upper_last) & ~svc;
    assign wd_err = bad_wr | timeout;

    assign restart = svc | ((state_q == wdcm_pkg::WDCM_WAIT_HIGH) & fault_pin_high);
    assign hold_end = tick & (hold_q == wdcm_pkg::RELEASE_TC - 5'h01);

    // ==========================================================
    // window state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            wdcm_pkg::WDCM_RUN: begin
                if (wd_err) begin
                    state_d = wdcm_pkg::WDCM_PULL;
                end
            end
            wdcm_pkg::WDCM_PULL: begin
                if (!fault_pin_high) begin
                    state_d = wdcm_pkg::WDCM_HOLD;
                end
            end
            wdcm_pkg::WDCM_HOLD: begin
                if (hold_end) begin
                    state_d = wdcm_pkg::WDCM_WAIT_HIGH;
                end
            end
            wdcm_pkg::WDCM_WAIT_HIGH: begin
                if (fault_pin_high) begin
                    state_d = wdcm_pkg::WDCM_RUN;
                end
            end
            default: begin
                state_d = wdcm_pkg::WDCM_RUN;
            end
        endcase
        if (!wd_active) begin
            state_d = wdcm_pkg::WDCM_RUN;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= wdcm_pkg::WDCM_RUN;
            idle_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idle_q <= idle_mode;
        end
    end

    // ==========================================================
    // configuration, locked by the first keyed write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_done_q <= 1'b0;
            win_sel_q <= wdcm_pkg::WIN_SEL_RESET;
            cm_en_q <= wdcm_pkg::CM_EN_RESET;
        end else if (first_ok) begin
            cfg_done_q <= 1'b1;
            win_sel_q <= svr_req.data[wdcm_pkg::WIN_MSB:wdcm_pkg::WIN_LSB];
            cm_en_q <= svr_req.data[wdcm_pkg::CM_BIT];
        end
    end

    // ==========================================================
    // window counters
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            upper_limit_counter_q <= '0;
            lower_limit_counter_q <= '0;
        end else if (restart) begin
            upper_limit_counter_q <= '0;
            lower_limit_counter_q <= '0;
        end else if (running && tick) begin
            upper_limit_counter_q <= upper_limit_counter_q + 16'h0001;
            if (!lower_done) begin
                lower_limit_counter_q <= lower_limit_counter_q + 9'h001;
            end
        end
    end

    // hold counter, runs while the pin is seen low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (state_q != wdcm_pkg::WDCM_HOLD) begin
            hold_q <= '0;
        end else if (tick) begin
            hold_q <= hold_q + 5'h01;
        end
    end

    // ==========================================================
    // clock monitor, counts system clocks between oscillator edges
    assign osc_edge = osc_level & ~osc_prev_q;
    assign cm_mon_en = cm_en_q & wd_active;
    assign cm_fail = (cm_cnt_q == CM_LAST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
            cm_cnt_q <= '0;
        end else begin
            osc_prev_q <= osc_level;
            if (osc_edge) begin
                cm_cnt_q <= '0;
            end else if (!cm_fail) begin
                cm_cnt_q <= cm_cnt_q + CM_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cm_rel_q <= '0;
        end else if (cm_mon_en && cm_fail) begin
            cm_rel_q <= wdcm_pkg::RELEASE_TC;
        end else if (tick && cm_rel_q != 5'h00) begin
            cm_rel_q <= cm_rel_q - 5'h01;
        end
    end

    assign cm_drive = cm_mon_en & (cm_fail | (cm_rel_q != 5'h00));
    assign wd_drive = (state_q == wdcm_pkg::WDCM_PULL) | (state_q == wdcm_pkg::WDCM_HOLD);

    // ==========================================================
    // pin and read data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oe_n_q <= 1'b1;
            service_key_rdata <= '0;
        end else begin
            oe_n_q <= ~(wd_active & (wd_drive | cm_drive));
            service_key_rdata <= {win_sel_q, wdcm_pkg::KEY_READ, cm_en_q};
        end
    end

    assign port_g_bit_one_out = 1'b0;
    assign port_g_bit_one_oe_n = oe_n_q;
    assign port_g_bit_one_pullup_en = wd_active;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    early_fault_a: assert property (
        (wr_take && cfg_done_q && !lower_done) |=> (state_q == wdcm_pkg::WDCM_PULL))
        else $error("early service did not raise fault");

    timeout_fault_a: assert property (
        timeout |=> (state_q == wdcm_pkg::WDCM_PULL) ##1 !port_g_bit_one_oe_n)
        else $error("timeout did not drive fault pin");

    key_mismatch_a: assert property (
        (wr_take && !key_ok) |=> (state_q == wdcm_pkg::WDCM_PULL))
        else $error("bad key accepted");

    read_key_zero_a: assert property (
        service_key_rdata[wdcm_pkg::KEY_MSB:wdcm_pkg::KEY_LSB] == wdcm_pkg::KEY_READ)
        else $error("key visible on read");

    cfg_lock_a: assert property (
        cfg_done_q |=> ($stable(win_sel_q) && $stable(cm_en_q) && cfg_done_q))
        else $error("configuration changed after lock");

    restart_count_a: assert property (
        svc |=> (upper_limit_counter_q == 16'h0000 && lower_limit_counter_q == 9'h000))
        else $error("service did not restart counters");

    halt_freeze_a: assert property (
        (halt_mode && !restart) |=> $stable(upper_limit_counter_q))
        else $error("window advanced in halt");

    hold_entry_a: assert property (
        (state_q == wdcm_pkg::WDCM_PULL && !fault_pin_high && wd_active)
        |=> (state_q == wdcm_pkg::WDCM_HOLD && hold_q == 5'h00))
        else $error("hold not entered on low pin");

    cm_drive_a: assert property (
        (cm_mon_en && cm_fail) |=> !port_g_bit_one_oe_n [*2])
        else $error("monitor error not driving pin");

    ignore_active_a: assert property (
        (svr_req.wr && !in_run) |=> $stable(cfg_done_q) && $stable(win_sel_q))
        else $error("write taken while fault active");

endmodule // wdcm_watchdog

//--- test/test_windowed_watchdog_clock_monitor.sv
`timescale 1ns/1ns

module test_windowed_watchdog_clock_monitor;
    // ==========================================================
    // stimulus and observed signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic instr_cycle_en = 1'b0;
    logic opt_wd_disable = 1'b0;
    logic halt_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic osc_run = 1'b1;
    logic osc_pin = 1'b0;
    logic hold_low = 1'b0;
    logic [1:0] osc_div = 2'h0;
    wdcm_pkg::wdcm_svr_req_s svr_req = '0;
    logic [7:0] rdata;
    logic pin;
    logic pin_out;
    logic oe_n;
    logic pullup_en;
    logic [7:0] bad_vals [3] = '{8'h59, 8'h18, 8'h1B};
    int fail_count = 0;
    int total_checks = 0;
    int len;

    always #25 clock = ~clock;

    // one instruction tick every two clocks, oscillator toggles every four clocks
    // so each level lasts long enough to pass the three-stage pin filter
    always @(posedge clock) begin
        instr_cycle_en <= #5 ~instr_cycle_en;
        osc_div <= osc_div + 2'h1;
        if (osc_run && osc_div == 2'h3) begin
            osc_pin <= #5 ~osc_pin;
        end
    end

    wdcm_watchdog #(.CM_TIMEOUT_CYC(40)) u_wdcm_watchdog (
        .clock(clock),
        .rst_n(rst_n),
        .instr_cycle_en(instr_cycle_en),
        .opt_wd_disable(opt_wd_disable),
        .halt_mode(halt_mode),
        .idle_mode(idle_mode),
        .svr_req(svr_req),
        .service_key_rdata(rdata),
        .oscillator_input_pin(osc_pin),
        .port_g_bit_one_in(pin),
        .port_g_bit_one_out(pin_out),
        .port_g_bit_one_oe_n(oe_n),
        .port_g_bit_one_pullup_en(pullup_en)
    );

    wdcm_fault_pin_model u_wdcm_fault_pin_model (
        .clock(clock),
        .drive_val(pin_out),
        .drive_oe_n(oe_n),
        .pullup_en(pullup_en),
        .hold_low(hold_low),
        .pin(pin)
    );

    // ==========================================================
    // tasks
    task automatic report_and_stop;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic clocks(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask

    task automatic ticks(input int n);
        clocks(2 * n);
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic svr_write(input logic [7:0] data);
        svr_req.wr = 1'b1;
        svr_req.data = data;
        clocks(1);
        svr_req.wr = 1'b0;
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        clocks(16);
        rst_n = 1'b1;
    endtask

    // waits for a fault, then measures how long the pin is driven low
    task automatic fault(input int wait_max, input logic exp, output int low_len);
        int n;
        n = 0;
        low_len = 0;
        while (oe_n !== 1'b0 && n < wait_max) begin
            clocks(1);
            n++;
        end
        chk("fault_seen", {7'h00, exp}, {7'h00, oe_n === 1'b0});
        while (oe_n === 1'b0 && low_len < 400) begin
            clocks(1);
            low_len++;
        end
        clocks(10);
    endtask

    // ==========================================================
    // sequence
    initial begin
        do_reset();
        clocks(2);
        chk("rdata_reset", 8'hC1, rdata);
        chk("pullup_en", 8'h01, {7'h00, pullup_en});
        chk("pin_idle", 8'h01, {7'h00, pin});
        svr_write(8'h19);
        clocks(2);
        chk("rdata_cfg", 8'h01, rdata);
        chk("early_cfg_ok", 8'h01, {7'h00, oe_n});
        ticks(300);
        svr_write(8'h19);
        fault(20, 1'b0, len);
        svr_write(8'h19);
        clocks(10);
        svr_write(8'h00);
        fault(20, 1'b1, len);
        chk("low_len", 8'h01, {7'h00, len >= 24 && len <= 60});
        fault(40, 1'b0, len);
        ticks(210);
        svr_write(8'h19);
        fault(20, 1'b1, len);
        for (int i = 0; i < 3; i++) begin
            ticks(300);
            svr_write(bad_vals[i]);
            fault(20, 1'b1, len);
        end
        ticks(300);
        svr_write(8'h19);
        fault(20, 1'b0, len);
        ticks(8100);
        chk("no_early_timeout", 8'h01, {7'h00, oe_n});
        fault(400, 1'b1, len);
        ticks(300);
        svr_write(8'h19);
        fault(20, 1'b0, len);
        halt_mode = 1'b1;
        ticks(8300);
        chk("halt_inhibit", 8'h01, {7'h00, oe_n});
        halt_mode = 1'b0;
        svr_write(8'h19);
        fault(20, 1'b1, len);
        ticks(300);
        idle_mode = 1'b1;
        ticks(10);
        idle_mode = 1'b0;
        ticks(100);
        svr_write(8'h19);
        fault(20, 1'b1, len);
        halt_mode = 1'b1;
        osc_run = 1'b0;
        clocks(60);
        chk("cm_fail", 8'h00, {7'h00, oe_n});
        clocks(200);
        chk("cm_hold", 8'h00, {7'h00, oe_n});
        osc_run = 1'b1;
        clocks(30);
        chk("cm_min_hold", 8'h00, {7'h00, oe_n});
        clocks(50);
        chk("cm_release", 8'h01, {7'h00, oe_n});
        halt_mode = 1'b0;
        do_reset();
        svr_write(8'hC0);
        fault(20, 1'b1, len);
        svr_write(8'h58);
        clocks(2);
        chk("rdata_cfg2", 8'h40, rdata);
        osc_run = 1'b0;
        clocks(100);
        chk("cm_disabled", 8'h01, {7'h00, oe_n});
        osc_run = 1'b1;
        opt_wd_disable = 1'b1;
        clocks(2);
        chk("pullup_off", 8'h00, {7'h00, pullup_en});
        svr_write(8'h00);
        clocks(10);
        chk("wd_disabled", 8'h01, {7'h00, oe_n});
        report_and_stop();
    end

    // ==========================================================
    // hang guard
    initial begin
        #(70000 * 50);
        fail_count++;
        report_and_stop();
    end
endmodule // test_windowed_watchdog_clock_monitor

//--- test/wdcm_fault_pin_model.sv
`timescale 1ns/1ns

// ==========================================================
// fault line outside the block: pull-up, open-drain driver, external holder
module wdcm_fault_pin_model (
    // clock
    input wire logic clock,
    // block side of the pin
    input wire logic drive_val,
    input wire logic drive_oe_n,
    input wire logic pullup_en,
    // board side
    input wire logic hold_low,
    output logic pin
);
    // ==========================================================
    // floating line shows a changing pattern, never a stale value
    logic float_q = 1'b0;

    always @(posedge clock) begin
        float_q <= ~float_q;
    end

    always_comb begin
        if (!drive_oe_n) begin
            pin = drive_val;
        end else if (hold_low) begin
            pin = 1'b0;
        end else if (pullup_en) begin
            pin = 1'b1;
        end else begin
            pin = float_q;
        end
    end
endmodule // wdcm_fault_pin_model
